// [dac_loader_regs.svh]
// Constants for the quad converter loading logic
// How it works
// - Frame is 12 bits, MSB first, fixed fields
// - Low all-channel bit shuts every channel down
// - Low selected bit shuts addressed channel down
// - Code bits go to one addressed input register
// - Select rising edge commits frame to input register
// - Serial: low load strobe copies all inputs
// - Parallel: low write strobe loads addressed register
// - Address 00/01/10/11 selects A/B/C/D
// - Write strobe rising edge latches data bus
// - Load strobe high holds converter registers
// - Load low, write high: converters follow inputs
// - Both low: data passes to both registers
// - Load rising edge latches inputs into converters
// - Both strobes high: nothing changes
// - Shift serial input on clock while selected
// - Deselected ignores clock; load strobe unaffected
// - Clear zeroes inputs and converters, not shifter
`ifndef DAC_LOADER_REGS_SVH
`define DAC_LOADER_REGS_SVH

`define FRAME_BITS      12
`define FRAME_MSB       11
`define POS_ALL_PD      11
`define POS_SEL_PD      10
`define POS_CH_HI       9
`define POS_CH_LO       8
`define CODE_MSB        7
`define CODE_WIDTH      8
`define NUM_CHANNELS    4
`define CODE_ZERO       8'h00
`define FRAME_ZERO      12'h000
`define CNT_ZERO        4'h0
`define CNT_ONE         4'h1
`define CNT_MAX         4'hf
`define MASK_NONE       4'h0
`define MASK_ONE        4'h1
`define MASK_ALL        4'hf
`define POS_WRITE_N     10
`define POS_ADDR_HI     9
`define POS_ADDR_LO     8

`endif

// [dac_loader_pkg.sv]
// Types for the quad converter loading logic
package dac_loader_pkg;
  typedef logic [7:0] code_t;
  typedef logic [1:0] chan_t;
  typedef logic [3:0] chan_mask_t;
  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_DONE  = 3'b100
  } ser_state_t;
endpackage

// [dac_write_if.sv]
// Interface carrying input register writes between front end and bank
`timescale 1ns/1ps
interface dac_write_if;
  import dac_loader_pkg::*;
  logic  wr_en;
  chan_t wr_chan;
  code_t wr_code;
  modport src (output wr_en, output wr_chan, output wr_code);
  modport dst (input wr_en, input wr_chan, input wr_code);
endinterface

// [dac_serial_front.sv]
// Serial front end: shifter, frame commit and power-down decode
`timescale 1ns/1ps
`include "dac_loader_regs.svh"
module dac_serial_front
  import dac_loader_pkg::*;
(
  input  wire logic   i_clk_sys,
  input  wire logic   i_reset,
  input  wire logic   i_sclk,
  input  wire logic   i_select_n,
  input  wire logic   i_serial_in,
  dac_write_if.src    wr,
  output chan_mask_t  o_power_down,
  output logic        o_frame_error
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       sclk_d_reg;
  logic       sel_d_reg;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_reg  <= 3'b010;
      sync2_reg  <= 3'b010;
      sclk_d_reg <= 1'b0;
      sel_d_reg  <= 1'b1;
    end else begin
      sync1_reg  <= {i_sclk, i_select_n, i_serial_in};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sync2_reg[2];
      sel_d_reg  <= sync2_reg[1];
    end
  end
  logic sclk_rise;
  logic sel_rise;
  assign sclk_rise = sync2_reg[2] & ~sclk_d_reg & ~sync2_reg[1];
  assign sel_rise  = sync2_reg[1] & ~sel_d_reg & ~sync2_reg[2];

  // ----------------------------------------------------------------
  // Shift register and frame commit
  // ----------------------------------------------------------------
  logic [`FRAME_MSB:0] shift_reg, shift_next;
  logic [3:0]          cnt_reg, cnt_next;
  ser_state_t          state_reg, state_next;
  chan_mask_t          pd_reg, pd_next;
  logic                wen_reg, wen_next;
  chan_t               wch_reg, wch_next;
  code_t               wcode_reg, wcode_next;
  logic                err_reg, err_next;

  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    state_next = state_reg;
    pd_next    = pd_reg;
    wen_next   = 1'b0;
    wch_next   = wch_reg;
    wcode_next = wcode_reg;
    err_next   = err_reg;
    case (state_reg)
      SER_IDLE: begin
        if (sclk_rise) begin
          shift_next = {shift_reg[`FRAME_MSB-1:0], sync2_reg[0]};
          cnt_next   = `CNT_ONE;
          state_next = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (sclk_rise) begin
          shift_next = {shift_reg[`FRAME_MSB-1:0], sync2_reg[0]};
          if (cnt_reg != `CNT_MAX) begin
            cnt_next = cnt_reg + `CNT_ONE;
          end
        end else if (sel_rise) begin
          state_next = SER_DONE;
        end
      end
      SER_DONE: begin
        err_next   = (cnt_reg != 4'(`FRAME_BITS));
        wen_next   = 1'b1;
        wch_next   = shift_reg[`POS_CH_HI:`POS_CH_LO];
        wcode_next = shift_reg[`CODE_MSB:0];
        pd_next    = `MASK_NONE;
        if (!shift_reg[`POS_ALL_PD]) begin
          pd_next = `MASK_ALL;
        end else if (!shift_reg[`POS_SEL_PD]) begin
          pd_next = chan_mask_t'(`MASK_ONE << shift_reg[`POS_CH_HI:`POS_CH_LO]);
        end
        cnt_next   = `CNT_ZERO;
        state_next = SER_IDLE;
      end
      default: state_next = SER_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      shift_reg <= `FRAME_ZERO;
      cnt_reg   <= `CNT_ZERO;
      state_reg <= SER_IDLE;
      pd_reg    <= `MASK_NONE;
      wen_reg   <= 1'b0;
      wch_reg   <= 2'h0;
      wcode_reg <= `CODE_ZERO;
      err_reg   <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      state_reg <= state_next;
      pd_reg    <= pd_next;
      wen_reg   <= wen_next;
      wch_reg   <= wch_next;
      wcode_reg <= wcode_next;
      err_reg   <= err_next;
    end
  end

  assign wr.wr_en      = wen_reg;
  assign wr.wr_chan    = wch_reg;
  assign wr.wr_code    = wcode_reg;
  assign o_power_down  = pd_reg;
  assign o_frame_error = err_reg;
endmodule // dac_serial_front

// [dac_parallel_front.sv]
// Parallel front end: address decode and registered write strobe level
`timescale 1ns/1ps
`include "dac_loader_regs.svh"
module dac_parallel_front
  import dac_loader_pkg::*;
(
  input  wire logic   i_clk_sys,
  input  wire logic   i_reset,
  input  wire logic   i_write_n,
  input  wire logic   i_channel_sel_hi,
  input  wire logic   i_channel_sel_lo,
  input  wire code_t  i_parallel_code_bus,
  dac_write_if.src    wr,
  output logic        o_write_active
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1_reg <= 11'h400;
      sync2_reg <= 11'h400;
    end else begin
      sync1_reg <= {i_write_n, i_channel_sel_hi, i_channel_sel_lo, i_parallel_code_bus};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Write capture
  // ----------------------------------------------------------------
  logic  wen_reg, wen_next;
  chan_t wch_reg, wch_next;
  code_t wcode_reg, wcode_next;
  always_comb begin
    wen_next   = ~sync2_reg[`POS_WRITE_N];
    wch_next   = sync2_reg[`POS_ADDR_HI:`POS_ADDR_LO];
    wcode_next = sync2_reg[`CODE_MSB:0];
  end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wen_reg   <= 1'b0;
      wch_reg   <= 2'h0;
      wcode_reg <= `CODE_ZERO;
    end else begin
      wen_reg   <= wen_next;
      wch_reg   <= wch_next;
      wcode_reg <= wcode_next;
    end
  end
  assign wr.wr_en       = wen_reg;
  assign wr.wr_chan     = wch_reg;
  assign wr.wr_code     = wcode_reg;
  assign o_write_active = wen_reg;
endmodule // dac_parallel_front

// [quad_dac_double_buffer_loader.sv]
// Top of the quad converter loader: register bank and load control
`timescale 1ns/1ps
`include "dac_loader_regs.svh"
module quad_dac_double_buffer_loader
  import dac_loader_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  input  wire logic         i_parallel_mode,
  input  wire logic         i_clear_all_n,
  input  wire logic         i_convert_load_strobe_n,
  input  wire logic         i_sclk,
  input  wire logic         i_select_n,
  input  wire logic         i_serial_in,
  input  wire logic         i_write_n,
  input  wire logic         i_channel_sel_hi,
  input  wire logic         i_channel_sel_lo,
  input  wire logic [7:0]   i_parallel_code_bus,
  output logic [7:0]        o_input_code [4],
  output logic [7:0]        o_convert_code [4],
  output logic [3:0]        o_power_down,
  output logic              o_frame_error,
  output logic              o_write_active
);
  // ----------------------------------------------------------------
  // Front ends
  // ----------------------------------------------------------------
  dac_write_if ser_wr ();
  dac_write_if par_wr ();

  dac_serial_front u_ser (
    .i_clk_sys     (i_clk_sys),
    .i_reset       (i_reset),
    .i_sclk        (i_sclk),
    .i_select_n    (i_select_n),
    .i_serial_in   (i_serial_in),
    .wr            (ser_wr.src),
    .o_power_down  (o_power_down),
    .o_frame_error (o_frame_error)
  );

  dac_parallel_front u_par (
    .i_clk_sys           (i_clk_sys),
    .i_reset             (i_reset),
    .i_write_n           (i_write_n),
    .i_channel_sel_hi    (i_channel_sel_hi),
    .i_channel_sel_lo    (i_channel_sel_lo),
    .i_parallel_code_bus (i_parallel_code_bus),
    .wr                  (par_wr.src),
    .o_write_active      (o_write_active)
  );

  // ----------------------------------------------------------------
  // Control synchronisers
  // ----------------------------------------------------------------
  logic [2:0] csync1_reg;
  logic [2:0] csync2_reg;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      csync1_reg <= 3'b011;
      csync2_reg <= 3'b011;
    end else begin
      csync1_reg <= {i_parallel_mode, i_clear_all_n, i_convert_load_strobe_n};
      csync2_reg <= csync1_reg;
    end
  end
  logic par_mode;
  logic clear_act;
  logic load_act;
  assign par_mode  = csync2_reg[2];
  assign clear_act = ~csync2_reg[1];
  assign load_act  = ~csync2_reg[0];

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  function automatic logic hit(input chan_t sel, input int ch);
    hit = (sel == chan_t'(ch));
  endfunction

  logic  any_wr;
  chan_t sel_chan;
  code_t sel_code;
  always_comb begin
    if (par_mode) begin
      any_wr   = par_wr.wr_en;
      sel_chan = par_wr.wr_chan;
      sel_code = par_wr.wr_code;
    end else begin
      any_wr   = ser_wr.wr_en;
      sel_chan = ser_wr.wr_chan;
      sel_code = ser_wr.wr_code;
    end
  end

  // ----------------------------------------------------------------
  // Input and converter registers
  // ----------------------------------------------------------------
  code_t in_reg [`NUM_CHANNELS];
  code_t in_next [`NUM_CHANNELS];
  code_t cv_reg [`NUM_CHANNELS];
  code_t cv_next [`NUM_CHANNELS];

  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g++) begin : g_chan
      always_comb begin
        in_next[g] = in_reg[g];
        cv_next[g] = cv_reg[g];
        if (clear_act) begin
          in_next[g] = `CODE_ZERO;
          cv_next[g] = `CODE_ZERO;
        end else begin
          if (any_wr && hit(sel_chan, g)) begin
            in_next[g] = sel_code;
          end
          if (load_act) begin
            if (par_mode && any_wr && hit(sel_chan, g)) begin
              cv_next[g] = sel_code;
            end else begin
              cv_next[g] = in_reg[g];
            end
          end
          // Load strobe high leaves converter register held
        end
      end
      always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
          in_reg[g] <= `CODE_ZERO;
          cv_reg[g] <= `CODE_ZERO;
        end else begin
          in_reg[g] <= in_next[g];
          cv_reg[g] <= cv_next[g];
        end
      end
      assign o_input_code[g]   = in_reg[g];
      assign o_convert_code[g] = cv_reg[g];
    end
  endgenerate
endmodule // quad_dac_double_buffer_loader

// [dac_serial_host.sv]
// Host-side serial frame sender for the converter loader
`timescale 1ns/1ps
module dac_serial_host (
  input  wire logic i_clk_sys,
  output logic      o_sclk,
  output logic      o_select_n,
  output logic      o_serial_in
);
  initial begin
    o_sclk = 1'b0;
    o_select_n = 1'b1;
    o_serial_in = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Sends the low n bits of a frame, then commits with clock low
  task automatic send(input logic [11:0] frame, input int n);
    o_select_n = 1'b0;
    hold(3);
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_in = frame[i];
      hold(3);
      o_sclk = 1'b1;
      hold(3);
      o_sclk = 1'b0;
    end
    hold(3);
    o_select_n = 1'b1;
    o_serial_in = ~o_serial_in;
    hold(3);
  endtask
  // Clocks while deselected, then an empty select pulse
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b1;
      hold(3);
      o_sclk = 1'b0;
      hold(3);
    end
    o_select_n = 1'b0;
    hold(3);
    o_select_n = 1'b1;
    hold(3);
  endtask
endmodule // dac_serial_host

// [quad_dac_double_buffer_loader_props.sv]
// Checker for the quad converter loader
`timescale 1ns/1ps
module dac_loader_props (
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  input wire logic       i_parallel_mode,
  input wire logic       i_clear_all_n,
  input wire logic       i_convert_load_strobe_n,
  input wire logic       i_sclk,
  input wire logic       i_select_n,
  input wire logic       i_serial_in,
  input wire logic       i_write_n,
  input wire logic       i_channel_sel_hi,
  input wire logic       i_channel_sel_lo,
  input wire logic [7:0] i_parallel_code_bus,
  input wire logic [7:0] o_input_code [4],
  input wire logic [7:0] o_convert_code [4],
  input wire logic [3:0] o_power_down,
  input wire logic       o_frame_error,
  input wire logic       o_write_active
);
  logic [31:0] inp_w;
  logic [31:0] cnv_w;
  assign inp_w = {o_input_code[3], o_input_code[2], o_input_code[1], o_input_code[0]};
  assign cnv_w = {o_convert_code[3], o_convert_code[2], o_convert_code[1], o_convert_code[0]};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence quiet_s;
    (i_select_n && i_write_n && i_clear_all_n)[*8];
  endsequence
  sequence load_s;
    (!i_convert_load_strobe_n && i_select_n && i_write_n && i_clear_all_n)[*8];
  endsequence
  input_quiet_a: assert property (quiet_s |-> $stable(inp_w))
    else $error("input code moved");
  load_copy_a: assert property (load_s |-> cnv_w == inp_w)
    else $error("converter differs");
  conv_hold_a: assert property ((i_convert_load_strobe_n && i_clear_all_n)[*5] |-> $stable(cnv_w))
    else $error("converter moved");
  clear_zero_a: assert property ((!i_clear_all_n)[*4] |-> (inp_w | cnv_w) == 32'h0)
    else $error("clear failed");
  pd_commit_a: assert property ($changed(o_power_down) |-> i_select_n && $past(i_select_n, 3))
    else $error("power down moved");
  err_commit_a: assert property ($changed(o_frame_error) |-> $past(i_select_n, 3))
    else $error("frame error moved");
  write_seen_a: assert property ((!i_write_n)[*4] |-> o_write_active)
    else $error("write not seen");
  write_idle_a: assert property (i_write_n[*4] |-> !o_write_active)
    else $error("write seen idle");
endmodule // dac_loader_props
bind quad_dac_double_buffer_loader dac_loader_props u_props (.*);

// [tb_top.sv]
// Self-checking testbench for the quad converter loader
`timescale 1ns/1ps
module tb_top;
  import dac_loader_pkg::*;
  logic       clk, rst, mode, clr_n, ld_n, wr_n, a_hi, a_lo, ferr, wact;
  logic [3:0] pd;
  code_t      bus;
  code_t      inp [4];
  code_t      cnv [4];
  code_t      ei [4];
  code_t      ec [4];
  wire        sclk, sel_n, serial_in;
  int         mismatches, compares, cycles;
  quad_dac_double_buffer_loader DUT (.i_clk_sys(clk), .i_reset(rst), .i_parallel_mode(mode),
    .i_clear_all_n(clr_n), .i_convert_load_strobe_n(ld_n), .i_sclk(sclk), .i_select_n(sel_n),
    .i_serial_in(serial_in), .i_write_n(wr_n), .i_channel_sel_hi(a_hi), .i_channel_sel_lo(a_lo),
    .i_parallel_code_bus(bus), .o_input_code(inp), .o_convert_code(cnv), .o_power_down(pd),
    .o_frame_error(ferr), .o_write_active(wact));
  dac_serial_host host (.i_clk_sys(clk), .o_sclk(sclk), .o_select_n(sel_n), .o_serial_in(serial_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] pk(input code_t a [4]);
    return {a[3], a[2], a[1], a[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic t_serial;
    for (int c = 0; c < 4; c++) begin
      ei[c] = 8'h3c + 8'(c);
      host.send({2'b11, 2'(c), ei[c]}, 12);
      cyc(8);
      chk(pk(inp), pk(ei));
    end
    chk(pk(cnv), 32'h0);
    chk(pd, 4'h0);
    ei[2] = 8'hff;
    host.send({4'b1010, ei[2]}, 12);
    cyc(8);
    chk(pd, 4'b0100);
    host.send({4'b0101, ei[1]}, 12);
    cyc(8);
    chk(pd, 4'hf);
    host.send({4'b1111, 8'h77}, 11);
    cyc(8);
    chk(ferr, 1'b1);
    host.send({4'b1111, ei[3]}, 12);
    cyc(8);
    chk({ferr, pd}, 5'h0);
    chk(pk(inp), pk(ei));
    $display("serial test done");
  endtask
  task automatic t_load;
    ld_n = 1'b0;
    cyc(10);
    chk(pk(cnv), pk(ei));
    ld_n = 1'b1;
    cyc(5);
    ec = ei;
    ei[0] = 8'h99;
    host.send({4'b1100, ei[0]}, 12);
    cyc(8);
    chk(pk(cnv), pk(ec));
    chk(pk(inp), pk(ei));
    host.stray(4);
    cyc(8);
    chk({ferr, pd}, 5'h0);
    chk(pk(inp), pk(ei));
    $display("load test done");
  endtask
  task automatic pwrite(input int c, input code_t d);
    {a_hi, a_lo} = 2'(c);
    bus = d;
    wr_n = 1'b0;
    cyc(5);
    chk(wact, 1'b1);
    wr_n = 1'b1;
    cyc(5);
  endtask
  task automatic t_parallel;
    mode = 1'b1;
    cyc(4);
    for (int c = 0; c < 4; c++) begin
      ei[c] = 8'hc0 + 8'(c);
      pwrite(c, ei[c]);
      chk(pk(inp), pk(ei));
    end
    chk(pk(cnv), pk(ec));
    ld_n = 1'b0;
    cyc(6);
    chk(pk(cnv), pk(ei));
    {a_hi, a_lo} = 2'b01;
    bus = 8'he7;
    wr_n = 1'b0;
    cyc(5);
    chk(cnv[1], 8'he7);
    bus = 8'he8;
    cyc(5);
    chk({inp[1], cnv[1]}, 16'he8e8);
    wr_n = 1'b1;
    cyc(3);
    ld_n = 1'b1;
    cyc(5);
    ei[1] = 8'he8;
    ec = ei;
    ei[2] = 8'h01;
    pwrite(2, ei[2]);
    chk(pk(cnv), pk(ec));
    chk(pk(inp), pk(ei));
    bus = 8'h55;
    a_hi = 1'b0;
    cyc(8);
    chk(pk(inp), pk(ei));
    $display("parallel test done");
  endtask
  task automatic t_clear;
    clr_n = 1'b0;
    cyc(5);
    chk(pk(inp) | pk(cnv), 32'h0);
    clr_n = 1'b1;
    cyc(5);
    chk(pk(inp) | pk(cnv), 32'h0);
    $display("clear test done");
  endtask
  initial begin
    {rst, mode, clr_n, ld_n, wr_n, a_hi, a_lo} = 7'h5c;
    bus = 8'h00;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    ec = '{default: 8'h00};
    ei = '{default: 8'h00};
    cyc(20);
    rst = 1'b0;
    cyc(2);
    chk(pk(inp) | pk(cnv), 32'h0);
    t_serial();
    t_load();
    t_parallel();
    t_clear();
    conclude();
  end
endmodule // tb_top
